// *** adc_readout_control.sv ***
// Purpose: conversion sequencing and serial result readout
// Assumes: pins synchronous to ref_clk; results arrive via a small FIFO
// Notes: conversion clock source detected from activity on the select pin
`timescale 1ns/1ps
`include "adc_readout_defs.svh"

module result_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module adc_readout_control
   import adc_readout_pkg::*;
#(
   parameter int CONV_CYCLES = `CONV_CYCLES,
   parameter int EXT_CONV_PERIODS = `EXT_CONV_PERIODS,
   parameter int OSC_CYCLES = `OSC_CYCLES,
   parameter int DETECT_CYCLES = `DETECT_CYCLES,
   parameter int POR_CYCLES = `POR_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_n,
   output logic sdo_out,
   output logic sdo_oe_n,
   input wire logic conversion_clock_select_pin,
   input wire result_type result_data,
   input wire logic result_valid,
   output logic result_ready,
   output logic conv_start,
   output logic ext_osc_active
);
   conv_state_type state_r;
   logic [31:0] conv_cnt_r;
   logic [31:0] por_cnt_r;
   logic por_done_r;
   logic [31:0] det_cnt_r;
   logic ext_r;
   logic f0_d_r;
   logic [31:0] osc_cnt_r;
   logic cclk_tick;
   logic cs_d_r;
   logic sck_d_r;
   logic ext_sck_r;
   logic [2:0] div_r;
   logic isck_r;
   logic [18:0] shreg_r;
   logic [4:0] fall_cnt_r;
   logic rise_seen_r;
   logic fifo_ready;
   logic [16:0] fifo_data;
   logic fifo_valid;
   logic take_result;
   logic sck_lvl;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_fall;
   logic conv_end;

   result_fifo #(.WIDTH(17), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_data(result_data),
      .in_valid(result_valid),
      .in_ready(fifo_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(take_result)
   );

   // ----------------------------------------------------------------
   // conversion clock source
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         f0_d_r <= 1'b0;
         det_cnt_r <= '0;
         ext_r <= 1'b0;
      end else begin
         f0_d_r <= conversion_clock_select_pin;
         // an edge within one slowest-clock period keeps external mode alive
         if (conversion_clock_select_pin && !f0_d_r) begin
            det_cnt_r <= '0;
            ext_r <= 1'b1; // R23
         end else if (det_cnt_r >= DETECT_CYCLES) begin
            ext_r <= 1'b0; // R23
         end else begin
            det_cnt_r <= det_cnt_r + 1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || ext_r) begin
         osc_cnt_r <= '0;
      end else if (osc_cnt_r >= OSC_CYCLES - 1) begin
         osc_cnt_r <= '0;
      end else begin
         osc_cnt_r <= osc_cnt_r + 1;
      end
   end

   // one tick per conversion clock period from either source
   assign cclk_tick = ext_r ? (conversion_clock_select_pin && !f0_d_r) : (osc_cnt_r >= OSC_CYCLES - 1); // R20

   // ----------------------------------------------------------------
   // pin edges and serial clock mode
   // ----------------------------------------------------------------
   assign sck_lvl = ext_sck_r ? sck_in : isck_r;
   assign sck_rise = sck_lvl && !sck_d_r;
   assign sck_fall = !sck_lvl && sck_d_r;
   assign cs_rise = cs_n && !cs_d_r;
   assign cs_fall = !cs_n && cs_d_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cs_d_r <= 1'b1;
         sck_d_r <= 1'b1;
         por_cnt_r <= '0;
         por_done_r <= 1'b0;
         ext_sck_r <= 1'b0;
      end else begin
         cs_d_r <= cs_n;
         sck_d_r <= sck_lvl;
         if (!por_done_r) begin
            if (por_cnt_r >= POR_CYCLES - 1) begin
               por_done_r <= 1'b1;
               ext_sck_r <= !sck_in; // R17
            end else begin
               por_cnt_r <= por_cnt_r + 1;
            end
         end else if (cs_fall) begin
            ext_sck_r <= !sck_in; // R10 R19
         end
      end
   end

   // internal serial clock: conversion clock divided by eight
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         div_r <= '0;
         isck_r <= 1'b1;
      end else if (state_r == st_output && !ext_sck_r && !cs_n) begin
         // low on entry, then four ticks low, four high
         if (cclk_tick) begin
            div_r <= div_r + 3'h1; // R21
            if (div_r == 3'h3 || div_r == 3'h7) begin
               isck_r <= !isck_r; // R21
            end
         end
      end else if (state_r == st_sleep && !ext_sck_r && !cs_n) begin
         isck_r <= 1'b0;
         div_r <= '0;
      end else begin
         isck_r <= 1'b1;
         div_r <= '0;
      end
   end

   // ----------------------------------------------------------------
   // state sequencing
   // ----------------------------------------------------------------
   assign conv_end = (conv_cnt_r >= (ext_r ? EXT_CONV_PERIODS : CONV_CYCLES) - 1); // R1 R2
   assign take_result = (state_r == st_convert) && conv_end && fifo_valid;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r <= st_convert; // R24
         conv_cnt_r <= '0;
         shreg_r <= '0;
         fall_cnt_r <= '0;
         rise_seen_r <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         unique case (state_r)
            st_convert: begin
               // serial clock edges are not looked at here
               if (!por_done_r) begin
                  conv_cnt_r <= '0;
               end else if (take_result) begin
                  conv_cnt_r <= '0;
                  shreg_r <= {1'b0, 1'b0, fifo_data}; // R18 R22
                  state_r <= st_sleep; // R3 R9
               end else if ((ext_r && cclk_tick) || (!ext_r && !conv_end)) begin
                  conv_cnt_r <= conv_cnt_r + 1; // R25
               end
               fall_cnt_r <= '0;
               rise_seen_r <= 1'b0;
            end
            st_sleep: begin
               if (!cs_n && sck_rise) begin
                  state_r <= st_output; // R3
                  rise_seen_r <= 1'b1;
               end
            end
            st_output: begin
               if (cs_rise) begin
                  state_r <= st_convert; // R7 R8
                  conv_start <= 1'b1;
               end else if (sck_fall) begin
                  shreg_r <= {shreg_r[17:0], 1'b1}; // R13
                  fall_cnt_r <= fall_cnt_r + 5'h1;
                  if (fall_cnt_r == 5'(`FRAME_BITS - 1)) begin
                     state_r <= st_convert; // R4 R5 R6 R15
                     conv_start <= 1'b1;
                  end
               end
            end
            default: state_r <= st_convert;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin drivers, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sdo_out <= 1'b1;
         sdo_oe_n <= 1'b1;
         sck_out <= 1'b1;
         sck_oe_n <= 1'b1;
         result_ready <= 1'b0;
         ext_osc_active <= 1'b0;
      end else begin
         sdo_oe_n <= cs_n; // R11 R16
         if (state_r == st_convert) begin
            sdo_out <= 1'b1; // R12 R15
         end else begin
            sdo_out <= shreg_r[18]; // R12 R13 R14
         end
         sck_out <= isck_r;
         sck_oe_n <= ext_sck_r || !por_done_r;
         result_ready <= fifo_ready;
         ext_osc_active <= ext_r;
      end
   end
endmodule

// *** adc_readout_defs.svh ***
// Purpose: constants for the converter readout sequencer
// Assumes: ref_clk at 100 MHz
// Notes: times in their own unit, cycle counts derived from them
//
// Contract
// R1 - select pin low: internal oscillator, convert lasts 147 ms, about 6.8 results/s.
// R2 - external conversion clock: convert lasts 20510 external clock periods.
// R3 - conversion ends with chip select high: sleep until select low and clock edge.
// R4 - internal serial clock, internal oscillator: output ends after 19 cycles or select rise. Code stays in sleep, internal clock held low.
// R5 - internal serial clock, external oscillator: output covers 19 serial clock cycles, 152 periods. Code stays in sleep, internal clock held low.
// R6 - external serial clock: output lasts at most 19 clock periods, ends on select rise.
// R7 - select rising after output began aborts transfer and starts a new conversion.
// R8 - abort honoured from first rising edge to the 19th falling edge.
// R9 - select held low: convert continuously at maximum rate.
// R10 - select falling samples clock pin; low picks external serial clock mode.
// R11 - data output floats whenever chip select is high.
// R12 - select low in convert or sleep: output shows end flag, high converting, low sleeping.
// R13 - result held static in sleep, output changes on falling clock edges.
// R14 - host captures end flag on first rise, last bit on 19th rise.
// R15 - on 19th falling edge start new conversion and drive output high.
// R16 - host may keep select low to watch end flag, or raise it to float output.
// R17 - clock mode chosen at end of power-on reset; host holds clock low before.
// R18 - two-wire: result loaded into shift register when end flag falls.
// R19 - four interface configurations: external/internal clock, single cycle/two-wire.
// R20 - every configuration works with internal or external conversion clock.
// R21 - internal serial clock is conversion clock divided by eight, driven out.
// R22 - frame is 19 bits: end flag, dummy zero, sign, 16 magnitude bits msb first.
// R23 - external clock of at least 2560 Hz detected on select pin, else internal.
// R24 - three-state controller convert, sleep, output; convert after reset.
// R25 - serial clock edges during convert are ignored.
`ifndef ADC_READOUT_DEFS_SVH
`define ADC_READOUT_DEFS_SVH
`define CLK_PERIOD_NS 10
`define CONV_TIME_MS 147
`define CONV_CYCLES ((`CONV_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define EXT_CONV_PERIODS 20510
`define FRAME_BITS 19
`define SCK_DIV 8
`define OSC_PERIOD_NS 3300
`define OSC_CYCLES (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define DETECT_MIN_HZ 2560
`define DETECT_NS (1000000000 / `DETECT_MIN_HZ)
`define DETECT_CYCLES (`DETECT_NS / `CLK_PERIOD_NS)
`define FIFO_DEPTH 8
`define POR_TIME_MS 1
`define POR_CYCLES ((`POR_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// *** adc_readout_pkg.sv ***
package adc_readout_pkg;
   typedef enum logic [1:0] {st_convert, st_sleep, st_output} conv_state_type;
   typedef struct packed {
      logic sign_bit;
      logic [15:0] magnitude;
   } result_type;
   typedef struct packed {
      logic eoc_n;
      logic dummy_bit;
      logic sign_bit;
      logic [15:0] magnitude;
   } frame_type;
endpackage

// *** adc_readout_checker.sv ***
// Purpose: concurrent checks on the readout sequencer ports
// Assumes: single ref_clk domain, sync active-low reset
// Notes: edge helpers allow a few cycles of pin sampling delay
`timescale 1ns/1ps
module adc_readout_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck_in,
   input wire logic sdo_out,
   input wire logic sdo_oe_n,
   input wire logic result_ready,
   input wire logic conv_start,
   input wire logic ext_osc_active
);
   logic sck_q;
   logic active;
   logic [4:0] falls;
   logic [3:0] since_fall;
   wire logic fell_w = sck_q && !sck_in;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge ref_clk) begin
      sck_q <= sck_in;
   end
   // saturating age of the last serial clock fall
   always_ff @(posedge ref_clk) begin
      if (!rst_n || fell_w) since_fall <= 4'h0;
      else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
   end
   // a frame opens on a rise seen while the flag is low
   always_ff @(posedge ref_clk) begin
      if (!rst_n || cs_n || conv_start) begin
         active <= 1'b0;
         falls <= 5'h00;
      end else if (!sck_q && sck_in && !sdo_out) begin
         active <= 1'b1;
      end else if (active && fell_w) begin
         falls <= falls + 5'h01;
      end
   end
   chk_reset_values: assert property ($rose(rst_n) |-> sdo_oe_n && sdo_out && !conv_start && !result_ready)
      else $error("outputs left reset state early");
   chk_float_cs_high: assert property (cs_n |=> sdo_oe_n)
      else $error("data output driven with select high");
   chk_drive_cs_low: assert property (!cs_n ##1 !cs_n |-> !sdo_oe_n)
      else $error("data output floating with select low");
   chk_convert_high: assert property (conv_start |-> ##2 sdo_out [*8])
      else $error("flag low early in conversion");
   chk_start_single: assert property (conv_start |=> !conv_start)
      else $error("restart pulse too long");
   chk_start_after_fall: assert property (conv_start && !cs_n |-> since_fall <= 4'd6)
      else $error("restart without a clock fall");
   chk_rise_on_fall: assert property ($rose(sdo_out) && !cs_n && !$past(cs_n) |-> since_fall <= 4'd6)
      else $error("data changed without a clock fall");
   chk_abort_restart: assert property ($rose(cs_n) && active |-> ##[0:6] conv_start)
      else $error("abort did not restart conversion");
   chk_frame_end: assert property (falls == 5'd19 |-> ##[0:6] conv_start)
      else $error("frame did not end after nineteen falls");
   cov_abort: cover property ($rose(cs_n) && active);
   cov_full_frame: cover property (falls == 5'd19);
   cov_ext_clock: cover property ($rose(ext_osc_active));
endmodule
bind adc_readout_control adc_readout_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
   .sck_in(sck_in), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .result_ready(result_ready),
   .conv_start(conv_start), .ext_osc_active(ext_osc_active));

// *** serial_host.sv ***
// Purpose: host serial master driving select and clock, capturing data
// Assumes: called from a process aligned to falling ref_clk edges
// Notes: clock idles low so every select fall picks external clocking
`timescale 1ns/1ps
module serial_host #(
   parameter int HALF = 4
) (
   input wire logic ref_clk,
   input wire logic sdo_pin,
   output logic cs_n,
   output logic sck
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
   end
   task automatic set_cs(input logic v);
      @(negedge ref_clk);
      cs_n = v;
   endtask
   // capture just before the rise, the device shifts on the fall
   task automatic read_bits(input int n, inout logic [18:0] f);
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         f = {f[17:0], sdo_pin};
         sck = 1'b1;
         repeat (HALF) @(negedge ref_clk);
         sck = 1'b0;
         repeat (HALF - 1) @(negedge ref_clk);
      end
   endtask
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the readout sequencer
// Assumes: external serial clock mode, shortened counts
// Notes: results enter through the fifo, frames are read by the host model
`timescale 1ns/1ps
module tb_top;
   import adc_readout_pkg::*;
   typedef struct packed {
      logic cs_low;
      result_type val;
      logic [18:0] exp;
   } row_type;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic res_valid = 1'b0;
   logic sel_pin = 1'b0;
   logic ext_en = 1'b0;
   result_type res_data = '0;
   logic cs_n, host_sck, sck_out, sck_oe_n, sdo_out, sdo_oe_n, res_ready, conv_start, ext_osc;
   wire logic sck_pin = sck_oe_n ? host_sck : sck_out;
   wire logic sdo_pin = sdo_oe_n ? 1'b1 : sdo_out; // pulled up when floating
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   logic [18:0] frame = '0;
   row_type rows [8] = '{
      '{1'b0, 17'h10000, 19'h10000}, '{1'b1, 17'h0ffff, 19'h0ffff}, '{1'b1, 17'h08000, 19'h08000},
      '{1'b0, 17'h17fff, 19'h17fff}, '{1'b1, 17'h00001, 19'h00001}, '{1'b0, 17'h1ffff, 19'h1ffff},
      '{1'b1, 17'h00000, 19'h00000}, '{1'b1, 17'h0aaaa, 19'h0aaaa}};
   adc_readout_control #(.CONV_CYCLES(200), .EXT_CONV_PERIODS(20), .OSC_CYCLES(2), .DETECT_CYCLES(100),
      .POR_CYCLES(10)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck_in(sck_pin),
      .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
      .conversion_clock_select_pin(sel_pin), .result_data(res_data), .result_valid(res_valid),
      .result_ready(res_ready), .conv_start(conv_start), .ext_osc_active(ext_osc));
   serial_host host (.ref_clk(ref_clk), .sdo_pin(sdo_pin), .cs_n(cs_n), .sck(host_sck));
   always #5 ref_clk = ~ref_clk;
   always #200 if (ext_en) sel_pin <= ~sel_pin;
   task automatic check(input logic [18:0] seen, input logic [18:0] want, input string what);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   task automatic wrap_up();
      if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_low(input int lim);
      n = 0;
      while (sdo_pin !== 1'b0 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         $display("[FAIL] %0t run hung", $time);
         wrap_up();
      end
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      check(19'({sdo_oe_n, sdo_out, conv_start, res_ready}), 19'h0000c, "reset outputs");
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      // fill the fifo until it refuses; the ninth word must be dropped
      for (int i = 0; i < 9; i++) begin
         res_data = rows[i % 8].val;
         res_valid = 1'b1;
         @(negedge ref_clk);
         res_valid = 1'b0;
         @(negedge ref_clk);
         check(19'(res_ready), 19'(i < 7), "fifo ready");
      end
      check(19'(sck_oe_n), 19'h1, "clock pin input");
      for (int i = 0; i < 8; i++) begin
         if (rows[i].cs_low) begin
            host.set_cs(1'b0);
            host.read_bits(3, frame);
            wait_low(3000);
            check(19'(i > 5 ? n > 300 : n < 250), 19'h1, "convert length");
         end else begin
            repeat (260) @(negedge ref_clk);
            host.set_cs(1'b0);
            repeat (2) @(negedge ref_clk);
            check(19'(sdo_pin), 19'h0, "sleep flag");
         end
         ext_en = ext_en | (i == 5);
         host.read_bits(19, frame);
         check(frame, rows[i].exp, "frame");
         repeat (3) @(negedge ref_clk);
         check(19'(sdo_pin), 19'h1, "flag after frame");
         host.set_cs(1'b1);
      end
      check(19'(ext_osc), 19'h1, "external clock seen");
      check(19'(res_ready), 19'h1, "fifo drained");
      host.set_cs(1'b0);
      wait_low(2500);
      check(19'(n), 19'd2500, "no result without data");
      res_data = 17'h05a5a;
      res_valid = 1'b1;
      @(negedge ref_clk);
      res_valid = 1'b0;
      wait_low(3000);
      host.read_bits(5, frame);
      host.set_cs(1'b1);
      n = 0;
      while (conv_start !== 1'b1 && n < 8) begin
         @(negedge ref_clk);
         n++;
      end
      check(19'(n < 8), 19'h1, "abort restarts");
      check(19'(frame[4:0]), 19'h00001, "leading bits");
      check(19'(sdo_oe_n), 19'h1, "float after abort");
      res_data = 17'h1c3c3;
      res_valid = 1'b1;
      @(negedge ref_clk);
      res_valid = 1'b0;
      host.set_cs(1'b0);
      wait_low(3000);
      host.read_bits(19, frame);
      check(frame, 19'h1c3c3, "frame after abort");
      wrap_up();
   end
endmodule
